// ### src/pvs_link_if.sv
// Purpose: carrier between port core, synthesizer and slot formatter
// Assumes: all signals on pclk
// Notes: none
`timescale 1ns/1ps
interface pvs_link_if;
  logic hi_rate;
  logic [1:0] rate_code;
  logic [7:0] inc;
  logic [12:0] limit;
  logic half_tick;
  logic [15:0] tx_sample;
  logic [1:0] fmt;
  pvs_pkg::pvs_pad_e pad;
  logic [2:0] atten;
  logic lsb_first;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [15:0] rx_sample;
  modport synth (input hi_rate, input rate_code, input inc, input limit, output half_tick);
  modport fmtr (input tx_sample, input fmt, input pad, input atten, input lsb_first, input rx_word,
    output tx_word, output rx_sample);
  modport core (output hi_rate, output rate_code, output inc, output limit, input half_tick,
    output tx_sample, output fmt, output pad, output atten, output lsb_first, output rx_word,
    input tx_word, input rx_sample);
endinterface

// ### src/pvs_pkg.sv
// Purpose: shared constants and types of the voice serial port
// Assumes: 100 MHz pclk, APB register access
// Notes: all offsets are byte addresses
package pvs_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NCH = 3;
  localparam int unsigned ADDR_W = 8;

  // register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_FINE = 8'h04;
  localparam logic [7:0] OFS_CHMAP = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TX0 = 8'h10;
  localparam logic [7:0] OFS_RX0 = 8'h20;

  // reset values
  localparam logic [31:0] CFG_RST = 32'h0080_0000;
  localparam logic [31:0] FINE_RST = 32'h0808_0177;
  localparam logic [31:0] CHMAP_RST = 32'h0000_0004;

  // audio_port_config_word fields
  localparam int unsigned CFG_SLAVE = 1;
  localparam int unsigned CFG_SHORT = 2;
  localparam int unsigned CFG_SIGNEXT = 4;
  localparam int unsigned CFG_LSBF = 5;
  localparam int unsigned CFG_TRIS_RISE = 7;
  localparam int unsigned CFG_SUPPRESS = 8;
  localparam int unsigned CFG_GCI = 9;
  localparam int unsigned CFG_MUTE = 10;
  localparam int unsigned CFG_HIRATE = 11;
  localparam int unsigned CFG_LONG16 = 12;
  localparam int unsigned CFG_RATE_LO = 21;
  localparam int unsigned CFG_FMT_LO = 27;

  // fine_clock_config_word fields
  localparam int unsigned FINE_LIMIT_LO = 0;
  localparam int unsigned FINE_LIMIT_W = 13;
  localparam int unsigned FINE_INC_LO = 16;
  localparam int unsigned FINE_SYNC_LO = 24;

  // channel map: per channel slot[1:0], enable at bit 2
  localparam int unsigned CH_FIELD_W = 4;
  localparam int unsigned CH_EN_BIT = 2;
  localparam int unsigned CHMAP_ATTEN_LO = 16;
  localparam int unsigned CHMAP_ATTEN_EN = 19;

  // status fields
  localparam int unsigned STAT_RXFULL_LO = 0;
  localparam int unsigned STAT_TAKEN_LO = 3;
  localparam int unsigned STAT_FRAME = 8;

  // rate and format codes
  localparam logic [1:0] RATE_256 = 2'b00;
  localparam logic [1:0] RATE_128 = 2'b01;
  localparam logic [1:0] RATE_512 = 2'b10;
  localparam logic [1:0] FMT_13 = 2'b00;
  localparam logic [1:0] FMT_16 = 2'b01;
  localparam logic [1:0] FMT_8W = 2'b10;
  localparam logic [1:0] FMT_8N = 2'b11;

  // synthesizers
  localparam int unsigned LO_SRC_HZ = 4_000_000;
  localparam int unsigned HI_SRC_HZ = 48_000_000;
  localparam int unsigned TICK_MOD = CLK_HZ / 1_000_000;
  localparam int unsigned LO_STEP = LO_SRC_HZ / 1_000_000;
  localparam int unsigned HI_STEP = HI_SRC_HZ / 1_000_000;
  localparam int unsigned LO_DDS_MOD = LO_SRC_HZ / 1000;
  localparam int unsigned BCLK_128_KHZ = 128;
  localparam int unsigned BCLK_256_KHZ = 256;
  localparam int unsigned BCLK_512_KHZ = 512;

  // framing
  localparam int unsigned FRAME_HZ = 8000;
  localparam int unsigned FLEN_128 = BCLK_128_KHZ * 1000 / FRAME_HZ;
  localparam int unsigned FLEN_256 = BCLK_256_KHZ * 1000 / FRAME_HZ;
  localparam int unsigned FLEN_512 = BCLK_512_KHZ * 1000 / FRAME_HZ;
  localparam int unsigned SYNC_LONG_BITS = 8;
  localparam int unsigned SYNC_LONG16_BITS = 16;
  localparam int unsigned SYNC_DIV_MULT = 8;
  localparam int unsigned SLOTS = 4;

  typedef enum logic [1:0] {PAD_ZERO, PAD_SIGN, PAD_ATTEN} pvs_pad_e;
endpackage

// ### src/pvs_port.sv
// Purpose: three-channel synchronous voice serial port with apb registers
// Assumes: slave bit clock at most 4.096 MHz against 100 MHz pclk
// Notes: slave pins are oversampled, so data edges lag the pin edges by 2-3 pclk
`timescale 1ns/1ps

module pvs_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pcm_bit_clock_i,
  output logic pcm_bit_clock_o,
  output logic pcm_bit_clock_oe_n,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe_n,
  output logic serial_audio_out_o,
  output logic serial_audio_out_oe_n,
  input wire logic serial_audio_in_i
);
  localparam int unsigned NCH = pvs_pkg::NCH;

  pvs_link_if lk ();

  logic [31:0] cfg_q;
  logic [31:0] fine_q;
  logic [31:0] chmap_q;
  logic [15:0] tx_q [NCH];
  logic [15:0] rx_q [NCH];
  logic rxfull_q [NCH];
  logic taken_q [NCH];
  logic [NCH-1:0] stat_rx;
  logic [NCH-1:0] stat_taken;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rmux;
  logic mapped;
  logic wr;

  logic bclk_s1, bclk_s2, bclk_s3;
  logic fs_s1, fs_s2;
  logic sin_s1, sin_s2;
  logic bclk_q;
  logic fs_q;
  logic fs_prev_q;
  logic rise_ev, fall_ev;
  logic slave, short_sync, gci, slen16;
  logic [10:0] flen;
  logic [10:0] sync_len;
  logic [10:0] pos_q;
  logic [10:0] pos_d;
  logic [10:0] pos_nx;
  logic start, start_sl;
  logic frame_ok_q;
  logic [NCH-1:0] hit_d, hit_cur, hit_nxt;
  logic [1:0] ch_d, ch_cur;
  logic [3:0] bit_d, bit_cur;
  logic last_cur;
  logic [15:0] tx_sh_q;
  logic sout_q;
  logic drive_q;
  logic load;
  logic [15:0] rx_sh_q;
  logic [1:0] rx_ch_q;
  logic rx_done_q;
  logic [1:0] tx_ch_q;
  logic tx_load_q;

  pvs_synth u_synth (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.synth)
  );

  pvs_slot_fmt u_fmt (
    .lk(lk.fmtr)
  );

  // slot decode of a bit position
  function automatic logic [2:0] slot_of(input logic [10:0] p, input logic s16);
    logic ok;
    ok = s16 ? (p < 11'(pvs_pkg::SLOTS * 16)) : (p < 11'(pvs_pkg::SLOTS * 8));
    return {ok, s16 ? p[5:4] : p[4:3]};
  endfunction

  // apb slave: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign wr = psel & penable & pwrite;
  assign mapped = (paddr == pvs_pkg::OFS_CFG) || (paddr == pvs_pkg::OFS_FINE) ||
    (paddr == pvs_pkg::OFS_CHMAP) || (paddr == pvs_pkg::OFS_STAT) ||
    (paddr >= pvs_pkg::OFS_TX0 && paddr < 8'(pvs_pkg::OFS_TX0 + 4 * NCH) && paddr[1:0] == 2'b00) ||
    (paddr >= pvs_pkg::OFS_RX0 && paddr < 8'(pvs_pkg::OFS_RX0 + 4 * NCH) && paddr[1:0] == 2'b00);

  always_comb begin
    rmux = 32'h0000_0000;
    if (paddr == pvs_pkg::OFS_CFG) begin
      rmux = cfg_q;
    end else if (paddr == pvs_pkg::OFS_FINE) begin
      rmux = fine_q;
    end else if (paddr == pvs_pkg::OFS_CHMAP) begin
      rmux = chmap_q;
    end else if (paddr == pvs_pkg::OFS_STAT) begin
      rmux[pvs_pkg::STAT_RXFULL_LO +: NCH] = stat_rx;
      rmux[pvs_pkg::STAT_TAKEN_LO +: NCH] = stat_taken;
      rmux[pvs_pkg::STAT_FRAME] = frame_ok_q;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (paddr == 8'(pvs_pkg::OFS_TX0 + 4 * i)) begin
          rmux = {16'h0000, tx_q[i]};
        end
        if (paddr == 8'(pvs_pkg::OFS_RX0 + 4 * i)) begin
          rmux = {16'h0000, rx_q[i]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel & !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rmux;
      pslverr_q <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= pvs_pkg::CFG_RST;
      fine_q <= pvs_pkg::FINE_RST;
      chmap_q <= pvs_pkg::CHMAP_RST;
    end else if (wr) begin
      if (paddr == pvs_pkg::OFS_CFG) begin
        cfg_q <= pwdata;
      end
      if (paddr == pvs_pkg::OFS_FINE) begin
        fine_q <= pwdata;
      end
      if (paddr == pvs_pkg::OFS_CHMAP) begin
        chmap_q <= pwdata;
      end
    end
  end

  // derived configuration
  assign slave = cfg_q[pvs_pkg::CFG_SLAVE];
  assign gci = cfg_q[pvs_pkg::CFG_GCI];
  assign short_sync = cfg_q[pvs_pkg::CFG_SHORT] & !gci;
  // gci forces 8-bit slots so slots 0 and 1 carry the two bearer channels
  assign lk.fmt = gci ? pvs_pkg::FMT_8N : cfg_q[pvs_pkg::CFG_FMT_LO +: 2];
  assign slen16 = lk.fmt != pvs_pkg::FMT_8N;
  assign lk.hi_rate = cfg_q[pvs_pkg::CFG_HIRATE];
  assign lk.rate_code = cfg_q[pvs_pkg::CFG_RATE_LO +: 2];
  assign lk.limit = fine_q[pvs_pkg::FINE_LIMIT_LO +: pvs_pkg::FINE_LIMIT_W];
  assign lk.inc = fine_q[pvs_pkg::FINE_INC_LO +: 8];
  assign lk.lsb_first = cfg_q[pvs_pkg::CFG_LSBF];
  assign lk.atten = chmap_q[pvs_pkg::CHMAP_ATTEN_LO +: 3];
  assign lk.pad = chmap_q[pvs_pkg::CHMAP_ATTEN_EN] ? pvs_pkg::PAD_ATTEN :
    (cfg_q[pvs_pkg::CFG_SIGNEXT] ? pvs_pkg::PAD_SIGN : pvs_pkg::PAD_ZERO);

  always_comb begin
    flen = {fine_q[pvs_pkg::FINE_SYNC_LO +: 8], 3'h0};
    if (!lk.hi_rate) begin
      unique case (lk.rate_code)
        pvs_pkg::RATE_128: flen = 11'(pvs_pkg::FLEN_128);
        pvs_pkg::RATE_512: flen = 11'(pvs_pkg::FLEN_512);
        default: flen = 11'(pvs_pkg::FLEN_256);
      endcase
    end
  end
  assign sync_len = (lk.hi_rate & cfg_q[pvs_pkg::CFG_LONG16]) ? 11'(pvs_pkg::SYNC_LONG16_BITS) :
    11'(pvs_pkg::SYNC_LONG_BITS);

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      sin_s1 <= 1'b0;
      sin_s2 <= 1'b0;
    end else begin
      bclk_s1 <= pcm_bit_clock_i;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      fs_s1 <= frame_sync_i;
      fs_s2 <= fs_s1;
      sin_s1 <= serial_audio_in_i;
      sin_s2 <= sin_s1;
    end
  end

  // master bit clock toggles on each synthesizer half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q <= 1'b0;
    end else if (lk.half_tick) begin
      bclk_q <= !bclk_q;
    end
  end

  assign rise_ev = slave ? (bclk_s2 & !bclk_s3) : (lk.half_tick & !bclk_q);
  assign fall_ev = slave ? (!bclk_s2 & bclk_s3) : (lk.half_tick & bclk_q);

  // frame position; slave sync is judged at rising edges, sync and clock share latency
  assign start_sl = short_sync ? (!fs_s2 & fs_prev_q) : (fs_s2 & !fs_prev_q);
  assign start = slave ? start_sl : (pos_d == 11'h000);
  always_comb begin
    if (slave) begin
      pos_d = start_sl ? 11'h000 : ((pos_q == 11'h7FF) ? pos_q : 11'(pos_q + 11'h001));
    end else begin
      pos_d = (pos_q >= 11'(flen - 11'h001)) ? 11'h000 : 11'(pos_q + 11'h001);
    end
  end
  assign pos_nx = 11'(pos_q + 11'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 11'h7FF; // no frame yet; master wraps to bit 0 on its first edge
      fs_prev_q <= 1'b0;
      fs_q <= 1'b0;
      frame_ok_q <= 1'b0;
    end else if (rise_ev) begin
      pos_q <= pos_d;
      fs_prev_q <= fs_s2;
      if (start) begin
        frame_ok_q <= 1'b1;
      end
      if (cfg_q[pvs_pkg::CFG_SUPPRESS]) begin
        fs_q <= 1'b0;
      end else if (short_sync) begin
        fs_q <= pos_d == 11'(flen - 11'h001);
      end else begin
        fs_q <= pos_d < sync_len;
      end
    end
  end

  // master drives clock and sync; slave releases both pins
  assign pcm_bit_clock_o = bclk_q;
  assign frame_sync_o = fs_q;
  assign pcm_bit_clock_oe_n = slave;
  assign frame_sync_oe_n = slave;

  // per channel slot match and registers
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [2:0] sd, sc, sn;
      logic [1:0] sel;
      logic en;
      assign sel = chmap_q[i * pvs_pkg::CH_FIELD_W +: 2];
      assign en = chmap_q[i * pvs_pkg::CH_FIELD_W + pvs_pkg::CH_EN_BIT];
      assign sd = slot_of(pos_d, slen16);
      assign sc = slot_of(pos_q, slen16);
      assign sn = slot_of(pos_nx, slen16);
      assign hit_d[i] = (frame_ok_q | start) & en & sd[2] & (sd[1:0] == sel);
      assign hit_cur[i] = frame_ok_q & en & sc[2] & (sc[1:0] == sel);
      assign hit_nxt[i] = frame_ok_q & en & sn[2] & (sn[1:0] == sel) & (pos_nx < flen | slave);
      assign stat_rx[i] = rxfull_q[i];
      assign stat_taken[i] = taken_q[i];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_q[i] <= 16'h0000;
        end else if (wr && paddr == 8'(pvs_pkg::OFS_TX0 + 4 * i)) begin
          tx_q[i] <= pwdata[15:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_q[i] <= 16'h0000;
        end else if (rx_done_q && rx_ch_q == 2'(i)) begin
          rx_q[i] <= lk.rx_sample;
        end
      end

      // status flags: hardware set wins over a write-one clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rxfull_q[i] <= 1'b0;
          taken_q[i] <= 1'b0;
        end else begin
          if (rx_done_q && rx_ch_q == 2'(i)) begin
            rxfull_q[i] <= 1'b1;
          end else if (wr && paddr == pvs_pkg::OFS_STAT && pwdata[pvs_pkg::STAT_RXFULL_LO + i]) begin
            rxfull_q[i] <= 1'b0;
          end
          if (tx_load_q && tx_ch_q == 2'(i)) begin
            taken_q[i] <= 1'b1;
          end else if (wr && paddr == pvs_pkg::OFS_STAT && pwdata[pvs_pkg::STAT_TAKEN_LO + i]) begin
            taken_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    ch_d = 2'h0;
    ch_cur = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (hit_d[i]) begin
        ch_d = 2'(i);
      end
      if (hit_cur[i]) begin
        ch_cur = 2'(i);
      end
    end
  end

  assign bit_d = slen16 ? pos_d[3:0] : {1'b0, pos_d[2:0]};
  assign bit_cur = slen16 ? pos_q[3:0] : {1'b0, pos_q[2:0]};
  assign last_cur = bit_cur == (slen16 ? 4'hF : 4'h7);
  assign lk.tx_sample = tx_q[ch_d];
  assign load = (|hit_d) & (bit_d == 4'h0);

  // transmit: launch on rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q <= 16'h0000;
      sout_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (rise_ev) begin
      drive_q <= |hit_d;
      if (load) begin
        tx_sh_q <= lk.tx_word;
        sout_q <= !cfg_q[pvs_pkg::CFG_MUTE] & lk.tx_word[15];
      end else begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
        sout_q <= !cfg_q[pvs_pkg::CFG_MUTE] & tx_sh_q[14];
      end
    end else if (fall_ev && !cfg_q[pvs_pkg::CFG_TRIS_RISE] && (|hit_cur) && last_cur && !(|hit_nxt)) begin
      drive_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load_q <= 1'b0;
      tx_ch_q <= 2'h0;
    end else begin
      tx_load_q <= rise_ev & load;
      if (rise_ev & load) begin
        tx_ch_q <= ch_d;
      end
    end
  end

  assign serial_audio_out_o = sout_q;
  assign serial_audio_out_oe_n = !drive_q;

  // receive: sample on falling edges, only inside active slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= 16'h0000;
      rx_ch_q <= 2'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= fall_ev & (|hit_cur) & last_cur;
      if (fall_ev && (|hit_cur)) begin
        rx_sh_q <= {rx_sh_q[14:0], sin_s2};
        rx_ch_q <= ch_cur;
      end
    end
  end

  assign lk.rx_word = rx_sh_q;
endmodule

// ### src/pvs_slot_fmt.sv
// Purpose: pack a sample into slot order and unpack a received slot
// Assumes: slot word is msb-first, 8-period slots use bits 15:8 out, 7:0 in
// Notes: lsb-first reverses the whole slot field, pad bits included
`timescale 1ns/1ps
module pvs_slot_fmt (
  pvs_link_if.fmtr lk
);
  logic [15:0] w;
  logic [15:0] r;
  logic [15:0] s;
  logic [15:0] w_rev, r_rev;
  logic [7:0] w_rev8, r_rev8;

  always_comb begin
    s = lk.tx_sample;
    w = s;
    unique case (lk.fmt)
      pvs_pkg::FMT_16: w = s;
      pvs_pkg::FMT_13: begin
        unique case (lk.pad)
          pvs_pkg::PAD_SIGN: w = {{3{s[12]}}, s[12:0]};
          pvs_pkg::PAD_ATTEN: w = {s[12:0], lk.atten};
          default: w = {s[12:0], 3'h0};
        endcase
      end
      pvs_pkg::FMT_8W: begin
        unique case (lk.pad)
          pvs_pkg::PAD_SIGN: w = {{8{s[7]}}, s[7:0]};
          pvs_pkg::PAD_ATTEN: w = {s[7:0], 5'h00, lk.atten};
          default: w = {s[7:0], 8'h00};
        endcase
      end
      default: w = {s[7:0], 8'h00};
    endcase
    w_rev = {<<{w}};
    w_rev8 = {<<{w[15:8]}};
    lk.tx_word = w;
    if (lk.lsb_first) begin
      lk.tx_word = (lk.fmt == pvs_pkg::FMT_8N) ? {w_rev8, 8'h00} : w_rev;
    end
  end

  always_comb begin
    r = lk.rx_word;
    r_rev = {<<{lk.rx_word}};
    r_rev8 = {<<{lk.rx_word[7:0]}};
    if (lk.lsb_first) begin
      r = (lk.fmt == pvs_pkg::FMT_8N) ? {8'h00, r_rev8} : r_rev;
    end
    unique case (lk.fmt)
      pvs_pkg::FMT_16: lk.rx_sample = r;
      pvs_pkg::FMT_13: lk.rx_sample = (lk.pad == pvs_pkg::PAD_SIGN) ? {{3{r[12]}}, r[12:0]} : {{3{r[15]}}, r[15:3]};
      pvs_pkg::FMT_8W: lk.rx_sample = (lk.pad == pvs_pkg::PAD_SIGN) ? {8'h00, r[7:0]} : {8'h00, r[15:8]};
      default: lk.rx_sample = {8'h00, r[7:0]};
    endcase
  end
endmodule

// ### src/pvs_synth.sv
// Purpose: dds bit clock half-period strobe from emulated 4 or 48 MHz source
// Assumes: pclk a whole multiple of 1 MHz
// Notes: edges carry up to one source period of jitter
`timescale 1ns/1ps
module pvs_synth (
  input wire logic pclk,
  input wire logic presetn,
  pvs_link_if.synth lk
);
  logic [6:0] src_q;
  logic [7:0] src_sum;
  logic src_tick;
  logic [13:0] dds_q;
  logic [14:0] dds_sum;
  logic [13:0] dds_mod;
  logic [13:0] dds_inc;
  logic dds_wrap;

  // source tick: fractional step of the source rate per pclk
  assign src_sum = {1'b0, src_q} + (lk.hi_rate ? 8'(pvs_pkg::HI_STEP) : 8'(pvs_pkg::LO_STEP));
  assign src_tick = src_sum >= 8'(pvs_pkg::TICK_MOD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 7'h00;
    end else begin
      src_q <= src_tick ? 7'(src_sum - 8'(pvs_pkg::TICK_MOD)) : src_sum[6:0];
    end
  end

  // low rate: two half periods per bit clock cycle over a kHz modulus
  always_comb begin
    dds_mod = 14'(pvs_pkg::LO_DDS_MOD);
    dds_inc = 14'(2 * pvs_pkg::BCLK_256_KHZ);
    if (lk.hi_rate) begin
      dds_mod = {1'b0, lk.limit};
      dds_inc = {6'h00, lk.inc};
    end else begin
      unique case (lk.rate_code)
        pvs_pkg::RATE_128: dds_inc = 14'(2 * pvs_pkg::BCLK_128_KHZ);
        pvs_pkg::RATE_512: dds_inc = 14'(2 * pvs_pkg::BCLK_512_KHZ);
        default: dds_inc = 14'(2 * pvs_pkg::BCLK_256_KHZ);
      endcase
    end
  end

  assign dds_sum = {1'b0, dds_q} + {1'b0, dds_inc};
  assign dds_wrap = dds_sum >= {1'b0, dds_mod};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dds_q <= 14'h0000;
    end else if (src_tick) begin
      dds_q <= dds_wrap ? 14'(dds_sum - {1'b0, dds_mod}) : dds_sum[13:0];
    end
  end

  // zero limit stops the clock rather than running wild
  assign lk.half_tick = src_tick & dds_wrap & (dds_mod != 14'h0000);
endmodule

// ### tb/pvs_codec_model.sv
// Purpose: codec answering the master port
// Assumes: port is master, long sync
// Notes: after the word, din toggles (line released)
`timescale 1ns/1ps
module pvs_codec_model #(parameter logic [15:0] PAT = 16'h3C96) (
  input wire logic pclk,
  input wire logic bclk,
  input wire logic fsync,
  output logic din
);
  logic b_q, f_q;
  int n;
  initial begin
    din = 1'b0; b_q = 1'b0; f_q = 1'b0; n = 16;
  end
  always @(posedge pclk) begin
    b_q <= bclk;
    f_q <= fsync;
    if (bclk && !b_q) begin
      if (fsync && !f_q) n = 0;
      if (n < 16) din <= PAT[15 - n]; else din <= !din;
      n = n + 1;
    end
  end
endmodule

// ### tb/pvs_port_properties.sv
// Purpose: pin timing checks of the voice port
// Assumes: rules judged from top ports only
// Notes: sync width accepts 1, 8 or 16 bits as config is hidden
`timescale 1ns/1ps
module pvs_port_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pcm_bit_clock_o,
  input wire logic pcm_bit_clock_oe_n,
  input wire logic frame_sync_o,
  input wire logic frame_sync_oe_n,
  input wire logic serial_audio_out_o,
  input wire logic serial_audio_out_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clk_q;
  logic [4:0] cnt_q, cnt_d;
  always_comb cnt_d = frame_sync_o ? cnt_q + {4'h0, pcm_bit_clock_o & !clk_q} : 5'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      clk_q <= pcm_bit_clock_o;
      cnt_q <= cnt_d;
    end
  end
  chk_sync_clock_align: assert property ($rose(frame_sync_o) |-> $rose(pcm_bit_clock_o))
    else $error("sync rose away from clock rise");
  chk_sync_width: assert property ($fell(frame_sync_o) |-> cnt_q inside {5'h01, 5'h08, 5'h10})
    else $error("sync width wrong");
  chk_out_launch: assert property ($changed(serial_audio_out_o) && !serial_audio_out_oe_n
    && !pcm_bit_clock_oe_n |-> $rose(pcm_bit_clock_o)) else $error("data changed off rising edge");
  chk_slot_start: assert property ($fell(serial_audio_out_oe_n) && !pcm_bit_clock_oe_n
    |-> $rose(pcm_bit_clock_o)) else $error("slot began off rising edge");
  chk_release_edge: assert property ($rose(serial_audio_out_oe_n) && !pcm_bit_clock_oe_n
    |-> $fell(pcm_bit_clock_o) || $rose(pcm_bit_clock_o)) else $error("release off clock edge");
  chk_pins_together: assert property (pcm_bit_clock_oe_n == frame_sync_oe_n)
    else $error("clock and sync drive differ");
  chk_clock_running: assert property (!pcm_bit_clock_oe_n |-> ##[1:1000] $changed(pcm_bit_clock_o))
    else $error("master clock stalled");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
endmodule
bind pvs_port pvs_port_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pcm_bit_clock_o(pcm_bit_clock_o), .pcm_bit_clock_oe_n(pcm_bit_clock_oe_n),
  .frame_sync_o(frame_sync_o), .frame_sync_oe_n(frame_sync_oe_n),
  .serial_audio_out_o(serial_audio_out_o), .serial_audio_out_oe_n(serial_audio_out_oe_n));

// ### tb/pvs_port_tb.sv
// Purpose: registers and slot 0 traffic of the voice port
// Assumes: master, long sync, clock and sync pins looped back
// Notes: one frame is 125 us, so few configs are run
`timescale 1ns/1ps
module pvs_port_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, bclk, bclk_oe_n, fs, fs_oe_n;
  logic sdo, sdo_oe_n, sdi;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic e;
  int err_count = 0, checks = 0;
  pvs_port dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pcm_bit_clock_i(bclk), .pcm_bit_clock_o(bclk), .pcm_bit_clock_oe_n(bclk_oe_n), .frame_sync_i(fs),
    .frame_sync_o(fs), .frame_sync_oe_n(fs_oe_n), .serial_audio_out_o(sdo),
    .serial_audio_out_oe_n(sdo_oe_n), .serial_audio_in_i(sdi));
  pvs_codec_model codec_u (.pclk(pclk), .bclk(bclk), .fsync(fs), .din(sdi));
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, pvs_pkg::OFS_CFG, 0); chk(r, pvs_pkg::CFG_RST);
    apb(0, pvs_pkg::OFS_FINE, 0); chk(r, pvs_pkg::FINE_RST);
    apb(0, pvs_pkg::OFS_CHMAP, 0); chk(r, pvs_pkg::CHMAP_RST);
    apb(0, 8'h40, 0); chk({r[30:0], e}, 32'h1);
  endtask
  task automatic t_slot(input logic [31:0] cfg, input int nb, input logic [15:0] tx, input logic [15:0] rx);
    logic [15:0] w;
    w = 16'h0000;
    apb(1, pvs_pkg::OFS_CFG, cfg);
    apb(1, pvs_pkg::OFS_TX0, 32'h0000_A5C3);
    @(posedge fs);
    for (int i = 0; i < nb; i++) begin
      @(negedge bclk);
      #1;
      w = {w[14:0], sdo};
      chk({31'h0, sdo_oe_n}, {31'h0, (i == nb - 1) && !cfg[7]});
    end
    chk({16'h0, w}, {16'h0, tx});
    repeat (3) @(negedge bclk);
    chk({31'h0, sdo_oe_n}, 32'h1);
    apb(0, pvs_pkg::OFS_RX0, 0); chk(r, {16'h0, rx});
    apb(0, pvs_pkg::OFS_STAT, 0); chk(r, 32'h0000_0109);
    apb(1, pvs_pkg::OFS_STAT, 32'h0000_003F);
  endtask
  // sync held low for a whole frame while the clock still runs
  task automatic t_quiet();
    apb(1, pvs_pkg::OFS_CFG, 32'h0080_0100);
    @(negedge bclk);
    repeat (33) begin
      @(negedge bclk);
      chk({31'h0, fs}, 32'h0);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_slot(32'h0880_0000, 16, 16'hA5C3, 16'h3C96);
    t_slot(32'h0880_0020, 16, 16'hC3A5, 16'h693C);
    t_slot(32'h0880_0400, 16, 16'h0000, 16'h3C96);
    t_slot(32'h1880_0000, 8, 16'h00C3, 16'h003C);
    t_slot(32'h0080_0010, 16, 16'h05C3, 16'hFC96);
    t_quiet();
    finish_test();
  end
endmodule
